// *** shared/scu_pkg.sv ***
// Package of the sensor chain command unit: codes, pointers, reset values,
// field positions, timing constants, state and carrier types.
// Assumes a 50 MHz system clock.
package scu_pkg;
  // Command byte fields and command codes
  localparam int        CMD_GLOBAL_BIT = 0;
  localparam int        CMD_READ_BIT   = 1;
  localparam int        CMD_CMDSEL_BIT = 2;
  localparam logic [7:0] CMD_LAST_POLL = 8'h57;
  localparam logic [7:0] CMD_SW_RESET  = 8'h5d;
  // Register pointers
  localparam logic [3:0] PTR_TEMP      = 4'h0;
  localparam logic [3:0] PTR_CONFIG    = 4'h1;
  localparam logic [3:0] PTR_NVM_FIRST = 4'h6;
  localparam logic [3:0] PTR_NVM_LAST  = 4'hd;
  localparam logic [3:0] PTR_DIE_ID    = 4'hf;
  // Temperature register fields
  localparam int TEMP_UNLOCK_BIT = 0;
  localparam int TEMP_BUSY_BIT   = 1;
  localparam int TEMP_LSB        = 2;
  // Configuration register fields
  localparam int CFG_RST_BIT = 1;
  localparam int CFG_SD_BIT  = 11;
  localparam int CFG_OS_BIT  = 12;
  localparam int CFG_FH1_BIT = 10;
  localparam int CFG_FL1_BIT = 9;
  localparam int CFG_FH2_BIT = 6;
  localparam int CFG_FL2_BIT = 5;
  localparam logic [15:0] CFG_STORE_MASK = 16'he998;
  // Reset values
  localparam logic [15:0] CFG_RESET   = 16'ha000;
  localparam logic [15:0] LIMIT_RESET = 16'h0000;
  localparam logic [15:0] NVM_RESET   = 16'h0000;
  localparam logic [15:0] DIE_ID      = 16'h1234; // Arbitrary value
  // Timing
  localparam int CLK_HZ       = 50_000_000;
  localparam int PROG_TIME_MS = 16;
  localparam int NVM_READ_US  = 100;
  localparam int TIMEOUT_MS   = 35;
  localparam int PROG_CYCLES  = CLK_HZ / 1000 * PROG_TIME_MS;
  localparam int NVM_RD_CYCLES = CLK_HZ / 1000000 * NVM_READ_US;
  localparam int TIMEOUT_CYCLES = CLK_HZ / 1000 * TIMEOUT_MS;

  typedef enum logic [2:0] {
    ST_CMD  = 3'b000,
    ST_PTR  = 3'b001,
    ST_DLO  = 3'b010,
    ST_DHI  = 3'b011,
    ST_WAIT = 3'b100,
    ST_TXLO = 3'b101,
    ST_TXHI = 3'b110
  } scu_state_e;

  // One conversion result with its four alert flags
  typedef struct packed {
    logic [13:0] temp;
    logic        fh1;
    logic        fl1;
    logic        fh2;
    logic        fl2;
  } scu_conv_s;

  // One register write request
  typedef struct packed {
    logic        go;
    logic [3:0]  ptr;
    logic [15:0] data;
  } scu_write_s;
endpackage

// *** rtl/scu_command_unit.sv ***
// Command and operation logic of one sensor in a daisy chain.
// Assumes a byte receiver/transmitter on clk beside it, link pins from
// outside (synchronised here) and an analog converter with start/done.
//
// Operation
// - Last chain device answers poll with address
// - Poll answered only if last at init
// - Software reset reloads nonvolatile, clears temperature
// - Config reset bit acts as software reset
// - Individual write touches only matching device
// - Individual read answers within 1.5 baud
// - Global write reaches devices up to address
// - Global read returns words descending to first
// - Global read beyond last times out 35ms
// - Continuous conversion default, updates temperature, flags
// - Shutdown stops conversions, registers stay accessible
// - One-shot in shutdown runs single conversion
// - One-shot bit always reads zero
// - Reset copies nonvolatile values into registers; resetn loads fixed values into both instead
// - Eight 16-bit nonvolatile words at 6h-Dh
// - Locked after power-up; locked writes ignored
// - Unlock bit enables, clearing relocks programming
// - Unlocked nonvolatile write programs up to 16ms
// - Busy flag shows programming in progress
// - Writes rejected while programming runs
// - Nonvolatile read stretches stop about 100us
// - Data sent low byte then high
// - Other devices pass traffic both directions
`timescale 1ns/1ps
module scu_command_unit #(
  parameter int PROG_CYCLES    = scu_pkg::PROG_CYCLES,
  parameter int NVM_RD_CYCLES  = scu_pkg::NVM_RD_CYCLES,
  parameter int TIMEOUT_CYCLES = scu_pkg::TIMEOUT_CYCLES
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  // Chain identity from the address-initialize logic
  input  wire logic [4:0]       dev_addr,
  input  wire logic             last_at_init,
  // Received bytes from the host side, start of a new frame
  input  wire logic             frame_start,
  input  wire logic             rx_valid,
  input  wire logic [7:0]       rx_byte,
  // Bytes seen passing up from downstream devices
  input  wire logic             down_valid,
  // Own byte transmitter
  output logic                  tx_valid,
  output logic [7:0]            tx_byte,
  input  wire logic             tx_ready,
  input  wire logic             tx_serial,
  output logic                  stop_stretch,
  output logic                  bus_timeout,
  // Link pins, level forwarding
  input  wire logic             io1_in,
  input  wire logic             io2_in,
  output logic                  io1_out,
  output logic                  io1_oe,
  output logic                  io2_out,
  output logic                  io2_oe,
  // Converter
  output logic                  conv_start,
  output logic                  conv_abort,
  input  wire logic             conv_done,
  input  wire scu_pkg::scu_conv_s conv_result,
  // Local register port
  input  wire logic [3:0]       reg_addr,
  input  wire logic [15:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [15:0]           reg_rdata
);

  // Pointer is backed by nonvolatile storage
  function automatic logic nv_backed(input logic [3:0] p);
    return (p >= scu_pkg::PTR_CONFIG) && (p <= scu_pkg::PTR_NVM_LAST);
  endfunction

  scu_pkg::scu_state_e state;
  scu_pkg::scu_state_e next_state;
  logic [15:0] regs [0:13];       // Working registers 0h-Dh
  logic [15:0] nvm  [1:13];       // Nonvolatile image of 1h-Dh
  logic        unlocked;
  logic        busy;
  logic [19:0] prog_cnt;
  logic [20:0] wait_cnt;
  logic [6:0]  turn_cnt;
  logic        converting;
  logic        one_shot;
  logic [7:0]  cmd;
  logic [3:0]  ptr;
  logic [7:0]  data_lo;
  logic [15:0] tx_word;
  logic        tx_single;
  logic        io1_s1, io1_s2, io2_s1, io2_s2;

  // Command byte decode
  wire logic        is_global  = cmd[scu_pkg::CMD_GLOBAL_BIT];
  wire logic        is_read    = cmd[scu_pkg::CMD_READ_BIT];
  wire logic        is_command = cmd[scu_pkg::CMD_CMDSEL_BIT];
  wire logic [4:0]  op_addr    = cmd[7:3];
  wire logic        addr_hit   = (op_addr == dev_addr);
  wire logic        in_range   = (dev_addr <= op_addr);
  wire logic        selected   = is_global ? in_range : addr_hit;
  wire logic [6:0]  my_turn    = {1'b0, op_addr - dev_addr, 1'b0};

  // Frame word and writes
  wire logic [15:0] frame_word = {rx_byte, data_lo};
  wire logic        last_byte  = (state == scu_pkg::ST_DHI) && rx_valid;
  wire logic        link_wr    = last_byte && selected && !is_read;
  wire logic        port_wr    = reg_wr && !link_wr;

  wire logic        cmd_reset  = (state == scu_pkg::ST_CMD) && rx_valid &&
                                 (rx_byte == scu_pkg::CMD_SW_RESET);
  // Shared write request, link wins a same-cycle collision
  scu_pkg::scu_write_s wr;
  assign wr.go   = link_wr || port_wr;
  assign wr.ptr  = link_wr ? ptr : reg_addr;
  assign wr.data = link_wr ? frame_word : reg_wdata;

  wire logic        wr_ok      = wr.go && !busy;
  wire logic        wr_temp    = wr_ok && (wr.ptr == scu_pkg::PTR_TEMP);
  wire logic        wr_cfg     = wr_ok && (wr.ptr == scu_pkg::PTR_CONFIG);
  wire logic        wr_gp      = wr_ok && (wr.ptr >= scu_pkg::PTR_NVM_FIRST) &&
                                 (wr.ptr <= scu_pkg::PTR_NVM_LAST) && unlocked;
  wire logic        wr_lim     = wr_ok && (wr.ptr > scu_pkg::PTR_CONFIG) &&
                                 (wr.ptr < scu_pkg::PTR_NVM_FIRST);
  wire logic        prog_go    = unlocked && !busy && wr.go &&
                                 nv_backed(wr.ptr);
  wire logic        sw_reset   = cmd_reset ||
                                 (wr_cfg && wr.data[scu_pkg::CFG_RST_BIT]);
  wire logic        shutdown   = regs[1][scu_pkg::CFG_SD_BIT];
  wire logic        os_go      = wr_cfg && wr.data[scu_pkg::CFG_OS_BIT] &&
                                 wr.data[scu_pkg::CFG_SD_BIT];

  // Register read mux, temperature carries status bits
  function automatic logic [15:0] reg_view(input logic [3:0] p);
    logic [15:0] v;
    v = 16'h0000;
    if (p == scu_pkg::PTR_TEMP) begin
      v = {regs[0][15:2], busy, unlocked};
    end else if (p == scu_pkg::PTR_DIE_ID) begin
      v = scu_pkg::DIE_ID;
    end else if (p <= scu_pkg::PTR_NVM_LAST) begin
      // one-shot and reset bits read zero (not stored)
      v = regs[p];
    end
    return v;
  endfunction

  // Frame sequencer next state
  always_comb begin
    next_state = state;
    unique case (state)
      scu_pkg::ST_CMD: begin
        if (rx_valid && !rx_byte[scu_pkg::CMD_CMDSEL_BIT]) begin
          next_state = scu_pkg::ST_PTR;
        end else if (rx_valid && (rx_byte == scu_pkg::CMD_LAST_POLL) &&
                     last_at_init) begin
          next_state = scu_pkg::ST_TXLO;
        end
      end
      scu_pkg::ST_PTR: begin
        if (rx_valid && is_read) begin
          next_state = selected ? scu_pkg::ST_WAIT : scu_pkg::ST_CMD;
        end else if (rx_valid) begin
          next_state = scu_pkg::ST_DLO;
        end
      end
      scu_pkg::ST_DLO: begin
        if (rx_valid) begin
          next_state = scu_pkg::ST_DHI;
        end
      end
      scu_pkg::ST_DHI: begin
        if (rx_valid) begin
          next_state = scu_pkg::ST_CMD;
        end
      end
      scu_pkg::ST_WAIT: begin
        if (wait_cnt == 21'(TIMEOUT_CYCLES)) begin
          next_state = scu_pkg::ST_CMD;
        end else if (turn_cnt >= my_turn && !stop_stretch) begin
          next_state = scu_pkg::ST_TXLO;
        end
      end
      scu_pkg::ST_TXLO: begin
        if (tx_valid && tx_ready) begin
          next_state = tx_single ? scu_pkg::ST_CMD : scu_pkg::ST_TXHI;
        end
      end
      scu_pkg::ST_TXHI: begin
        if (tx_valid && tx_ready) begin
          next_state = scu_pkg::ST_CMD;
        end
      end
      default: next_state = scu_pkg::ST_CMD;
    endcase
  end

  // State register, a new frame always restarts parsing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= scu_pkg::ST_CMD;
    end else if (frame_start) begin
      state <= scu_pkg::ST_CMD;
    end else begin
      state <= next_state;
    end
  end

  // Captured command, pointer and low data byte
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd     <= 8'h00;
      ptr     <= 4'h0;
      data_lo <= 8'h00;
    end else if (rx_valid) begin
      if (state == scu_pkg::ST_CMD) cmd <= rx_byte;
      if (state == scu_pkg::ST_PTR) ptr <= rx_byte[3:0];
      if (state == scu_pkg::ST_DLO) data_lo <= rx_byte;
    end
  end

  // wait for downstream words, stretch, timeout
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_cnt     <= 21'h000000;
      turn_cnt     <= 7'h00;
      stop_stretch <= 1'b0;
      bus_timeout  <= 1'b0;
    end else begin
      bus_timeout <= (state == scu_pkg::ST_WAIT) &&
                     (wait_cnt == 21'(TIMEOUT_CYCLES));
      if (state != scu_pkg::ST_WAIT) begin
        wait_cnt     <= 21'h000000;
        turn_cnt     <= 7'h00;
        stop_stretch <= rx_valid && (state == scu_pkg::ST_PTR) &&
                        is_read && nv_backed(rx_byte[3:0]);
      end else begin
        // Counter restarts on every passing byte
        wait_cnt <= down_valid ? 21'h000000 : wait_cnt + 21'h000001;
        if (down_valid) turn_cnt <= turn_cnt + 7'h01;
        if (wait_cnt == 21'(NVM_RD_CYCLES)) stop_stretch <= 1'b0;
      end
    end
  end

  // Own transmitter: low byte first, address reply
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_valid  <= 1'b0;
      tx_byte   <= 8'h00;
      tx_word   <= 16'h0000;
      tx_single <= 1'b0;
    end else if (state == scu_pkg::ST_CMD &&
                 next_state == scu_pkg::ST_TXLO && !frame_start) begin
      // poll reply only from init-time last device
      tx_valid  <= 1'b1;
      tx_byte   <= {3'b000, dev_addr};
      tx_single <= 1'b1;
    end else if (state == scu_pkg::ST_WAIT &&
                 next_state == scu_pkg::ST_TXLO && !frame_start) begin
      // answer the cycle after the turn arrives
      tx_valid  <= 1'b1;
      tx_word   <= reg_view(ptr);
      tx_byte   <= 8'(reg_view(ptr));
      tx_single <= 1'b0;
    end else if (tx_valid && tx_ready) begin
      tx_valid <= (state == scu_pkg::ST_TXLO) && !tx_single;
      tx_byte  <= tx_word[15:8];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      io1_s1 <= 1'b1;
      io1_s2 <= 1'b1;
      io2_s1 <= 1'b1;
      io2_s2 <= 1'b1;
    end else begin
      io1_s1 <= io1_in;
      io1_s2 <= io1_s1;
      io2_s1 <= io2_in;
      io2_s2 <= io2_s1;
    end
  end

  // Upstream carries own bits while sending, else downstream traffic
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      io1_out <= 1'b1;
      io1_oe  <= 1'b0;
      io2_out <= 1'b1;
      io2_oe  <= 1'b0;
    end else begin
      io1_oe  <= 1'b1;
      io2_oe  <= 1'b1;
      io2_out <= io1_s2;
      io1_out <= (tx_valid || state == scu_pkg::ST_TXHI) ? tx_serial : io2_s2;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      unlocked <= 1'b0;
      busy     <= 1'b0;
      prog_cnt <= 20'h00000;
    end else begin
      if (wr_temp) unlocked <= wr.data[scu_pkg::TEMP_UNLOCK_BIT];
      if (prog_go) begin
        busy     <= 1'b1;
        prog_cnt <= 20'h00000;
      end else if (busy) begin
        prog_cnt <= prog_cnt + 20'h00001;
        if (prog_cnt == 20'(PROG_CYCLES - 1)) busy <= 1'b0;
      end
    end
  end

  // nonvolatile image written only by programming
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 1; i <= 13; i++) begin
        nvm[i] <= (i == 1) ? scu_pkg::CFG_RESET :
                  (i < 6) ? scu_pkg::LIMIT_RESET : scu_pkg::NVM_RESET;
      end
    end else if (prog_go) begin
      nvm[wr.ptr] <= (wr.ptr == scu_pkg::PTR_CONFIG) ?
                     (wr.data & scu_pkg::CFG_STORE_MASK) : wr.data;
    end
  end

  // Conversion control: continuous, shutdown, one-shot
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      converting <= 1'b0;
      one_shot   <= 1'b0;
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
    end else begin
      conv_abort <= wr_cfg || sw_reset;
      conv_start <= 1'b0;
      if (wr_cfg || sw_reset) begin
        // Config write aborts; new settings decide next action
        converting <= 1'b0;
        one_shot   <= os_go;
      end else if (conv_done && converting) begin
        converting <= 1'b0;
        one_shot   <= 1'b0;
      end else if (!converting && (!shutdown || one_shot)) begin
        converting <= 1'b1;
        conv_start <= 1'b1;
      end
    end
  end

  // Working registers: reload on reset, results and flags
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regs[0] <= 16'h0000;
      regs[1] <= scu_pkg::CFG_RESET;
      for (int i = 2; i <= 13; i++) begin
        regs[i] <= (i < 6) ? scu_pkg::LIMIT_RESET : scu_pkg::NVM_RESET;
      end
    end else if (sw_reset) begin
      regs[0] <= 16'h0000;
      for (int i = 1; i <= 13; i++) begin
        regs[i] <= nvm[i];
      end
    end else begin
      if (conv_done && converting) begin
        regs[0][15:2] <= conv_result.temp;
        regs[1][scu_pkg::CFG_FH1_BIT] <= conv_result.fh1;
        regs[1][scu_pkg::CFG_FL1_BIT] <= conv_result.fl1;
        regs[1][scu_pkg::CFG_FH2_BIT] <= conv_result.fh2;
        regs[1][scu_pkg::CFG_FL2_BIT] <= conv_result.fl2;
      end
      if (wr_cfg) begin
        regs[1] <= (wr.data & scu_pkg::CFG_STORE_MASK) |
                   (regs[1] & ~scu_pkg::CFG_STORE_MASK);
      end
      if (wr_lim || wr_gp) regs[wr.ptr] <= wr.data;
    end
  end

  // Local port read data, one cycle after the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= reg_view(reg_addr);
    end
  end

endmodule // scu_command_unit

// *** tb/scu_monitor.sv ***
// Checker of the command unit on its register, transmit and pin ports.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps
module scu_monitor (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [7:0]  tx_byte,
  input wire logic        bus_timeout,
  input wire logic        conv_start,
  input wire logic        io1_in,
  input wire logic        io1_out,
  input wire logic        io1_oe,
  input wire logic        io2_out,
  input wire logic        io2_oe,
  input wire logic        io2_in,
  input wire logic        tx_serial
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic sd_wr;
  // Shutdown writes without the reset bit, which would restart conversions
  assign sd_wr = reg_wr && reg_addr == scu_pkg::PTR_CONFIG
                 && reg_wdata[scu_pkg::CFG_SD_BIT]
                 && !reg_wdata[scu_pkg::CFG_RST_BIT];

  a_os_zero: assert property (
    reg_rd && reg_addr == scu_pkg::PTR_CONFIG
    |=> !reg_rdata[scu_pkg::CFG_OS_BIT]) else $error("one-shot bit read one");
  a_die_id: assert property (
    reg_rd && reg_addr == scu_pkg::PTR_DIE_ID
    |=> reg_rdata == scu_pkg::DIE_ID) else $error("die id word wrong");
  a_tx_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("offered byte dropped or changed");
  a_timeout_pulse: assert property (
    bus_timeout |=> !bus_timeout) else $error("timeout not one cycle");
  a_fwd_down: assert property (
    io2_out == $past(io1_in, 3)) else $error("pin not forwarded");
  a_fwd_up: assert property (
    io1_out == ($past(tx_valid) ? $past(tx_serial) : $past(io2_in, 3)))
    else $error("pin not forwarded upstream");
  a_conv_pulse: assert property (
    conv_start |=> !conv_start) else $error("start not a pulse");
  a_sd_stop: assert property (
    sd_wr && !reg_wdata[scu_pkg::CFG_OS_BIT] |=> !conv_start [*8])
    else $error("conversion started in shutdown");
  a_os_start: assert property (
    sd_wr && reg_wdata[scu_pkg::CFG_OS_BIT] |-> ##[1:4] conv_start)
    else $error("single conversion not started");
  a_reset_idle: assert property (
    $rose(resetn) |-> io1_out && io2_out && !io1_oe && !io2_oe && !tx_valid)
    else $error("outputs not idle after reset");
endmodule // scu_monitor

bind scu_command_unit scu_monitor mon (.clk, .resetn, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_valid, .tx_ready, .tx_byte,
  .bus_timeout, .conv_start, .io1_in, .io1_out, .io1_oe, .io2_out, .io2_oe,
  .io2_in, .tx_serial);

// *** tb/scu_host_model.sv ***
// Host controller of the chain at byte level: sends frames, takes replies.
// Assumes the unit's byte handshake; slow makes the host stall replies.
`timescale 1ns/1ps
module scu_host_model (
  input  wire logic       clk,
  input  wire logic       tx_valid,
  input  wire logic       slow,
  output logic            tx_ready,
  output logic            frame_start,
  output logic            rx_valid,
  output logic [7:0]      rx_byte
);
  logic [1:0] gap = 2'h0;
  initial begin
    frame_start = 1'b0;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
  end
  // reply taking
  // Each reply byte is taken at its handshake; a slow host waits a while
  always @(posedge clk) begin
    gap <= gap + 2'h1;
    tx_ready <= tx_valid && (!slow || gap == 2'h3);
  end
  // frame order
  // Bytes leave low first; the idle byte lane is inverted, never stale
  task automatic send(input logic [31:0] f, input int n);
    @(posedge clk) frame_start <= 1'b1;
    @(posedge clk) frame_start <= 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk) begin
        rx_valid <= 1'b1;
        rx_byte <= f[8*i +: 8];
      end
      @(posedge clk) begin
        rx_valid <= 1'b0;
        rx_byte <= ~f[8*i +: 8];
      end
    end
  endtask
endmodule // scu_host_model

// *** tb/tb_top.sv ***
// Self-checking bench of the command unit beside a byte-level host model.
// Assumes shortened programming, fetch and timeout counts set below.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  mismatches++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top;
  localparam int         PC  = 50;
  localparam logic [3:0] TMP = scu_pkg::PTR_TEMP;
  localparam logic [3:0] CFG = scu_pkg::PTR_CONFIG;
  localparam logic [3:0] NV  = scu_pkg::PTR_NVM_FIRST;
  logic clk, resetn, last_at_init, down_valid, tx_ready, tx_serial, slow;
  logic frame_start, rx_valid, reg_wr, reg_rd, conv_done, io1_in, io2_in;
  logic tx_valid, stop_stretch, bus_timeout, conv_start, rd_d, conv_abort;
  logic io1_out, io1_oe, io2_out, io2_oe;
  logic [4:0]          dev_addr;
  logic [7:0]          rx_byte, tx_byte, et;
  logic [3:0]          reg_addr;
  logic [15:0]         reg_wdata, reg_rdata, v, w, er;
  scu_pkg::scu_conv_s  conv_result;
  logic [31:0]         seed = 32'hf6aa;
  int                  mismatches, checks_done, convs, i;
  logic [15:0]         qr[$];
  logic [7:0]          qt[$];

  scu_command_unit #(.PROG_CYCLES(PC), .NVM_RD_CYCLES(10),
    .TIMEOUT_CYCLES(100)) dut (.clk, .resetn, .dev_addr, .last_at_init,
    .frame_start, .rx_valid, .rx_byte, .down_valid, .tx_valid, .tx_byte,
    .tx_ready, .tx_serial, .stop_stretch, .bus_timeout, .io1_in, .io2_in,
    .io1_out, .io1_oe, .io2_out, .io2_oe, .conv_start, .conv_abort,
    .conv_done, .conv_result, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata);
  scu_host_model host (.clk, .tx_valid, .slow, .tx_ready, .frame_start,
    .rx_valid, .rx_byte);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Pins toggle at random; idle in reset so the forwarding delay starts known
  always @(posedge clk) begin
    {io1_in, io2_in, tx_serial} <= resetn ? 3'(rnd()) : 3'h7;
    if (conv_start) convs++;
  end
  // Each answer is matched with the oldest note of its kind
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d) begin
      er = qr.pop_front();
      `CHK(reg_rdata, er)
    end
    if (tx_valid && tx_ready) begin
      et = qt.size() ? qt.pop_front() : 8'hxx;
      `CHK(tx_byte, et)
    end
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk) begin
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
    end
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk) begin
      reg_rd <= 1'b1;
      reg_addr <= a;
      qr.push_back(e);
    end
    @(posedge clk) reg_rd <= 1'b0;
  endtask
  task automatic exp2(input logic [15:0] d);
    qt.push_back(d[7:0]);
    qt.push_back(d[15:8]);
  endtask
  task automatic wait_tx();
    for (int k = 0; k < 400 && qt.size() > 0; k++) @(posedge clk);
    `CHK(qt.size(), 0)
  endtask
  task automatic conv(input logic [13:0] t, input logic [3:0] f);
    @(posedge clk) begin
      conv_done <= 1'b1;
      conv_result <= {t, f};
    end
    @(posedge clk) begin
      conv_done <= 1'b0;
      conv_result <= ~conv_result;
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    close_out();
  end
  // Main sequence: register image, programming, modes, then link traffic
  initial begin
    {resetn, reg_wr, reg_rd, conv_done, down_valid, last_at_init} = '0;
    {slow, reg_addr, reg_wdata, conv_result} = '0;
    {io1_in, io2_in, tx_serial} = 3'h7;
    dev_addr = 5'd2;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rd(CFG, scu_pkg::CFG_RESET);
    rd(TMP, 16'h0000);
    for (int a = 2; a < 15; a++) rd(4'(a), 16'h0000);
    rd(4'hf, scu_pkg::DIE_ID);
    v = 16'(rnd());
    wr(NV, v);
    rd(NV, 16'h0000);
    wr(TMP, 16'h0001);
    rd(TMP, 16'h0001);
    wr(NV, v);
    rd(TMP, 16'h0003);
    wr(4'h2, 16'h5a5a);
    repeat (PC) @(posedge clk);
    rd(4'h2, 16'h0000);
    rd(TMP, 16'h0001);
    wr(TMP, 16'h0000);
    rd(TMP, 16'h0000);
    rd(NV, v);
    conv(14'h1abc, 4'hf);
    rd(TMP, 16'h6af0);
    rd(CFG, 16'ha660);
    wr(CFG, 16'h0002);
    repeat (2) @(posedge clk);
    rd(TMP, 16'h0000);
    rd(CFG, scu_pkg::CFG_RESET);
    rd(NV, v);
    wr(CFG, 16'ha800);
    @(negedge clk) convs = 0;
    `CHK(conv_abort, 1'b1)
    repeat (20) @(negedge clk);
    `CHK(convs, 0)
    wr(CFG, 16'hb800);
    repeat (6) @(negedge clk);
    `CHK(convs, 1)
    conv(14'h0123, 4'h0);
    repeat (20) @(negedge clk);
    `CHK(convs, 1)
    rd(CFG, 16'ha800);
    w = 16'(rnd());
    host.send({w, 8'h02, 8'h10}, 4);
    host.send({~w, 8'h03, 8'h18}, 4);
    host.send({w, 8'h04, 8'h21}, 4);
    host.send({~w, 8'h05, 8'h09}, 4);
    rd(4'h2, w);
    rd(4'h3, 16'h0000);
    rd(4'h4, w);
    rd(4'h5, 16'h0000);
    exp2(16'h048c);
    host.send({24'h0, 8'h12}, 2);
    repeat (2) @(negedge clk);
    `CHK(tx_valid, 1'b1)
    wait_tx();
    slow <= 1'b1;
    exp2(v);
    host.send({24'h6, 8'h12}, 2);
    repeat (3) @(negedge clk);
    `CHK(stop_stretch, 1'b1)
    `CHK(tx_valid, 1'b0)
    wait_tx();
    exp2(w);
    host.send({24'h2, 8'h23}, 2);
    repeat (20) @(negedge clk);
    `CHK(tx_valid, 1'b0)
    repeat (4) begin
      @(posedge clk) down_valid <= 1'b1;
      @(posedge clk) down_valid <= 1'b0;
    end
    wait_tx();
    host.send({24'h2, 8'h4b}, 2);
    for (i = 0; i < 150 && bus_timeout !== 1'b1; i++) @(posedge clk);
    `CHK(bus_timeout, 1'b1)
    `CHK(i > 90, 1'b1)
    host.send({24'h0, scu_pkg::CMD_LAST_POLL}, 1);
    repeat (20) @(negedge clk);
    `CHK(tx_valid, 1'b0)
    last_at_init <= 1'b1;
    qt.push_back({3'b000, dev_addr});
    host.send({24'h0, scu_pkg::CMD_LAST_POLL}, 1);
    wait_tx();
    host.send({24'h0, scu_pkg::CMD_SW_RESET}, 1);
    repeat (2) @(posedge clk);
    rd(TMP, 16'h0000);
    rd(CFG, scu_pkg::CFG_RESET);
    rd(4'h2, 16'h0000);
    wr(TMP, 16'h0001);
    @(posedge clk) resetn <= 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    rd(TMP, 16'h0000);
    rd(NV, scu_pkg::NVM_RESET);
    repeat (2) @(posedge clk);
    close_out();
  end
endmodule // tb_top
